/* csad_consts.svh */
// Purpose: offsets, field positions, reset values of the chip-select decoder
// Assumes: byte addresses on a 32-bit apb bus
// Notes:   definitions only
`ifndef CSAD_CONSTS_SVH
`define CSAD_CONSTS_SVH

`define CSAD_SPACE0_OFS     32'hffffe400
`define CSAD_SPACE1_OFS     32'hffffe404
`define CSAD_SPACE2_OFS     32'hffffe408
`define CSAD_SPACE3_OFS     32'hffffe40c
`define CSAD_ENABLE_OFS     32'hffffe410
`define CSAD_STATUS_OFS     32'hffffe414

`define CSAD_START_LSB      16
`define CSAD_START_MSB      31
`define CSAD_MASK_LSB       0
`define CSAD_MASK_MSB       15

`define CSAD_NARROW_RST     32'h000003ff
`define CSAD_WIDE_RST       32'h000001ff
`define CSAD_ENABLE_RST     4'h4

`define CSAD_NARROW_FLOOR   32'hffffc000
`define CSAD_WIDE_FLOOR     32'hffff8000
`define CSAD_EXCL_LO        32'hffff8000

`define CSAD_ST_FULL_BIT    8
`define CSAD_ST_MISS_BIT    5
`define CSAD_ST_EXCL_BIT    4

`endif

/* csad_pkg.sv */
// Purpose: types of the chip-select decoder
// Assumes: nothing
// Notes:   state of the top module is one packed struct
package csad_pkg;

   typedef logic [31:0] csad_word_t;

   typedef enum logic [1:0] {
      CSAD_IDLE = 2'b01,
      CSAD_RESP = 2'b10
   } csad_apb_e;

   typedef struct packed {
      csad_apb_e       apb;
      logic            pready;
      logic            pslverr;
      csad_word_t      prdata;
      csad_word_t [3:0] space;
      logic [3:0]      enable;
      logic            full_map;
      logic [3:0]      sel_n;
      logic            miss;
      logic [3:0]      last_sel;
      logic            last_excl;
      logic            last_miss;
   } csad_state_s;

endpackage : csad_pkg

/* csad_match.sv */
// Purpose: one chip-select space address comparator
// Assumes: start field is the top 16 address bits
// Notes:   purely combinational, one instance per space
`timescale 1ns/1ns
`include "csad_consts.svh"
module csad_match
   import csad_pkg::*;
#(
   parameter bit WIDE = 1'b0
) (
   input  wire logic [31:0] addr_in,
   input  wire logic [15:0] start_in,
   input  wire logic [15:0] mask_in,
   input  wire logic        enable_in,
   input  wire logic        full_in,
   output logic             hit_out
);

   // expand the 16-bit mask onto the address bits it governs
   function automatic csad_word_t care_bits(input logic [15:0] mask);
      csad_word_t m;
      csad_word_t floor_bits;
      if (WIDE) begin
         m          = {1'b0, mask, 15'h0000};                       // R2 R16
         floor_bits = `CSAD_WIDE_FLOOR;                              // R5
      end else begin
         m          = {2'b00, mask, 14'h0000};                       // R3 R16
         floor_bits = `CSAD_NARROW_FLOOR;                            // R4
      end
      care_bits = ~m & floor_bits;                                   // R12 R8
   endfunction : care_bits

   csad_word_t base;
   csad_word_t diff;

   always_comb begin
      base    = {start_in, 16'h0000};                                // R1 R13
      diff    = (addr_in ^ base) & care_bits(mask_in);
      hit_out = enable_in & (full_in | (diff == 32'h00000000));      // R15
   end

endmodule : csad_match

/* csad_decoder.sv */
// Purpose: chip-select address decoder with four base/mask spaces
// Assumes: apb register access, addresses synchronous to CLK_IN
// Notes:   select outputs are registered, one cycle after the address
//
// Operation
// R1: start field holds address bits 31..16, lower bits zero.
// R2: spaces two and three mask bits govern A30 down to A15.
// R3: spaces zero and one mask bits govern A29 down to A14.
// R4: spaces zero and one always compare A31 and A30.
// R5: spaces two and three always compare A31.
// R6: software writes zero to mask bits 15..9 of spaces two, three.
// R7: software writes zero to mask bits 15..10 of spaces zero, one.
// R8: sizes 16 KB (spaces 0,1) or 32 KB (2,3) up to 16 MB.
// R9: no select asserted inside the excluded address range.
// R10: after reset only space two enabled, covering all 4 GB.
// R11: overlapping matches select the lowest numbered space.
// R12: a set mask bit removes its address bit from comparison.
// R13: start addresses fall on 64 KB multiples.
// R14: software programs physical addresses into the registers.
// R15: select only when space enabled and all compared bits equal.
// R16: mask bit 15 maps to highest maskable bit, downward.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "csad_consts.svh"
module csad_decoder
   import csad_pkg::*;
(
   input  wire logic        CLK_IN,
   input  wire logic        RESET_N_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [31:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   input  wire logic [3:0]  PSTRB_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic [31:0] BUS_ADDR_IN,
   input  wire logic        BUS_ADDR_VALID_IN,
   output logic             SELECT_SPACE_ZERO_N_OUT,
   output logic             SELECT_SPACE_ONE_N_OUT,
   output logic             SELECT_SPACE_TWO_N_OUT,
   output logic             SELECT_SPACE_THREE_N_OUT,
   output logic             SPACE_MISS_OUT
);

   csad_state_s st;
   csad_state_s next_st;

   logic [3:0]  hit;
   logic [3:0]  onehot;
   logic        excluded;
   logic        setup;
   logic        access;
   logic        do_write;

   // byte lanes merge into the old word
   function automatic csad_word_t merge_strobe(
      input csad_word_t old_word,
      input csad_word_t new_word,
      input logic [3:0] strb
   );
      csad_word_t res;
      res = old_word;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_word[8*i +: 8];
         end
      end
      merge_strobe = res;
   endfunction : merge_strobe

   // register index decode, 3'd7 for unmapped
   function automatic logic [2:0] reg_index(input csad_word_t addr);
      logic [2:0] idx;
      idx = 3'd7;
      unique case (addr)
         `CSAD_SPACE0_OFS: idx = 3'd0;
         `CSAD_SPACE1_OFS: idx = 3'd1;
         `CSAD_SPACE2_OFS: idx = 3'd2;
         `CSAD_SPACE3_OFS: idx = 3'd3;
         `CSAD_ENABLE_OFS: idx = 3'd4;
         `CSAD_STATUS_OFS: idx = 3'd5;
         default:          idx = 3'd7;
      endcase
      reg_index = idx;
   endfunction : reg_index

   // fixed priority, lowest space number wins
   function automatic logic [3:0] lowest_first(input logic [3:0] req);
      logic [3:0] res;
      res = 4'h0;
      for (int i = 3; i >= 0; i--) begin
         if (req[i]) begin
            res = 4'h0;
            res[i] = 1'b1;
         end
      end
      lowest_first = res;
   endfunction : lowest_first

   // spaces zero and one use the narrow mask window
   csad_match #(
      .WIDE(1'b0)
   ) u_match0 (
      .addr_in   (BUS_ADDR_IN),
      .start_in  (st.space[0][`CSAD_START_MSB:`CSAD_START_LSB]),
      .mask_in   (st.space[0][`CSAD_MASK_MSB:`CSAD_MASK_LSB]),
      .enable_in (st.enable[0]),
      .full_in   (1'b0),
      .hit_out   (hit[0])
   );

   csad_match #(
      .WIDE(1'b0)
   ) u_match1 (
      .addr_in   (BUS_ADDR_IN),
      .start_in  (st.space[1][`CSAD_START_MSB:`CSAD_START_LSB]),
      .mask_in   (st.space[1][`CSAD_MASK_MSB:`CSAD_MASK_LSB]),
      .enable_in (st.enable[1]),
      .full_in   (1'b0),
      .hit_out   (hit[1])
   );

   // space two carries the reset-time whole-map window
   csad_match #(
      .WIDE(1'b1)
   ) u_match2 (
      .addr_in   (BUS_ADDR_IN),
      .start_in  (st.space[2][`CSAD_START_MSB:`CSAD_START_LSB]),
      .mask_in   (st.space[2][`CSAD_MASK_MSB:`CSAD_MASK_LSB]),
      .enable_in (st.enable[2]),
      .full_in   (st.full_map),
      .hit_out   (hit[2])
   );

   csad_match #(
      .WIDE(1'b1)
   ) u_match3 (
      .addr_in   (BUS_ADDR_IN),
      .start_in  (st.space[3][`CSAD_START_MSB:`CSAD_START_LSB]),
      .mask_in   (st.space[3][`CSAD_MASK_MSB:`CSAD_MASK_LSB]),
      .enable_in (st.enable[3]),
      .full_in   (1'b0),
      .hit_out   (hit[3])
   );

   always_comb begin
      next_st  = st;
      excluded = (BUS_ADDR_IN >= `CSAD_EXCL_LO);                     // R9
      onehot   = excluded ? 4'h0 : lowest_first(hit);                // R11 R9
      setup    = PSEL_IN & ~PENABLE_IN;
      access   = PSEL_IN & PENABLE_IN & st.pready;
      do_write = access & PWRITE_IN;

      // apb: one wait-free access phase, answer comes from flops
      unique case (st.apb)
         CSAD_IDLE: begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            if (setup) begin
               next_st.apb     = CSAD_RESP;
               next_st.pready  = 1'b1;
               next_st.pslverr = (reg_index(PADDR_IN) == 3'd7);
               next_st.prdata  = 32'h00000000;
               if (!PWRITE_IN) begin
                  unique case (reg_index(PADDR_IN))
                     3'd0: next_st.prdata = st.space[0];
                     3'd1: next_st.prdata = st.space[1];
                     3'd2: next_st.prdata = st.space[2];
                     3'd3: next_st.prdata = st.space[3];
                     3'd4: next_st.prdata = {28'h0000000, st.enable};
                     3'd5: begin
                        next_st.prdata[3:0]                 = st.last_sel;
                        next_st.prdata[`CSAD_ST_EXCL_BIT]   = st.last_excl;
                        next_st.prdata[`CSAD_ST_MISS_BIT]   = st.last_miss;
                        next_st.prdata[`CSAD_ST_FULL_BIT]   = st.full_map;
                     end
                     default: next_st.prdata = 32'h00000000;
                  endcase
               end
            end
         end
         CSAD_RESP: begin
            if (access) begin
               next_st.apb     = CSAD_IDLE;
               next_st.pready  = 1'b0;
               next_st.pslverr = 1'b0;
               next_st.prdata  = 32'h00000000;
            end
         end
      endcase

      // writes land at the edge that samples pready high
      // mask bits kept as written; clearing high bits is up to software
      if (do_write) begin                                            // R6 R7 R14
         unique case (reg_index(PADDR_IN))
            3'd0: next_st.space[0] = merge_strobe(st.space[0], PWDATA_IN, PSTRB_IN);
            3'd1: next_st.space[1] = merge_strobe(st.space[1], PWDATA_IN, PSTRB_IN);
            3'd2: begin
               next_st.space[2] = merge_strobe(st.space[2], PWDATA_IN, PSTRB_IN);
               next_st.full_map = 1'b0;                              // R10
            end
            3'd3: next_st.space[3] = merge_strobe(st.space[3], PWDATA_IN, PSTRB_IN);
            3'd4: begin
               if (PSTRB_IN[0]) begin
                  next_st.enable = PWDATA_IN[3:0];                   // R15
               end
            end
            default: begin
               next_st.enable = st.enable;
            end
         endcase
      end

      // selects follow the address by one cycle; idle bus selects nothing
      if (BUS_ADDR_VALID_IN) begin
         next_st.sel_n     = ~onehot;                                // R11
         next_st.miss      = (onehot == 4'h0);
         next_st.last_sel  = onehot;
         next_st.last_excl = excluded;                               // R9
         next_st.last_miss = (onehot == 4'h0);
      end else begin
         next_st.sel_n = 4'hf;
         next_st.miss  = 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         st           <= '0;
         st.apb       <= CSAD_IDLE;
         st.space[0]  <= `CSAD_NARROW_RST;
         st.space[1]  <= `CSAD_NARROW_RST;
         st.space[2]  <= `CSAD_WIDE_RST;
         st.space[3]  <= `CSAD_WIDE_RST;
         st.enable    <= `CSAD_ENABLE_RST;                           // R10
         st.full_map  <= 1'b1;                                       // R10
         st.sel_n     <= 4'hf;
      end else begin
         st <= next_st;
      end
   end

   // every output straight from a flip-flop
   assign PRDATA_OUT               = st.prdata;
   assign PREADY_OUT               = st.pready;
   assign PSLVERR_OUT              = st.pslverr;
   assign SELECT_SPACE_ZERO_N_OUT  = st.sel_n[0];
   assign SELECT_SPACE_ONE_N_OUT   = st.sel_n[1];
   assign SELECT_SPACE_TWO_N_OUT   = st.sel_n[2];
   assign SELECT_SPACE_THREE_N_OUT = st.sel_n[3];
   assign SPACE_MISS_OUT           = st.miss;

endmodule : csad_decoder

/* csad_asserts.sv */
// Purpose: port assertions of the chip-select decoder
// Assumes: ports of csad_decoder only
// Notes:   one clock domain
`timescale 1ns/1ns
module csad_asserts (
   input wire logic        CLK_IN,
   input wire logic        RESET_N_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic [31:0] PADDR_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PREADY_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic [31:0] BUS_ADDR_IN,
   input wire logic        BUS_ADDR_VALID_IN,
   input wire logic        SELECT_SPACE_ZERO_N_OUT,
   input wire logic        SELECT_SPACE_ONE_N_OUT,
   input wire logic        SELECT_SPACE_TWO_N_OUT,
   input wire logic        SELECT_SPACE_THREE_N_OUT,
   input wire logic        SPACE_MISS_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   logic [3:0] sel_n;
   assign sel_n = {SELECT_SPACE_THREE_N_OUT, SELECT_SPACE_TWO_N_OUT,
                   SELECT_SPACE_ONE_N_OUT, SELECT_SPACE_ZERO_N_OUT};
   sequence setup_s;
      PSEL_IN && !PENABLE_IN;
   endsequence
   sequence access_s;
      PSEL_IN && PENABLE_IN && PREADY_OUT;
   endsequence
   one_select_a: assert property ($countones(~sel_n) <= 1)
      else $error("two selects low");
   excl_none_a: assert property (BUS_ADDR_VALID_IN && BUS_ADDR_IN >= 32'hffff8000
      |=> sel_n == 4'hf && SPACE_MISS_OUT) else $error("select in excluded range");
   idle_none_a: assert property (!BUS_ADDR_VALID_IN |=> sel_n == 4'hf && !SPACE_MISS_OUT)
      else $error("select without address");
   hit_or_miss_a: assert property (BUS_ADDR_VALID_IN
      |=> $countones({~sel_n, SPACE_MISS_OUT}) == 1) else $error("no single outcome");
   zero_wait_a: assert property (setup_s |=> access_s) else $error("ready late");
   ready_pulse_a: assert property (access_s |=> !PREADY_OUT) else $error("ready too long");
   err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error without ready");
   rdata_quiet_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
      else $error("read data outside answer");
   unmapped_err_a: assert property ((setup_s and (PADDR_IN < 32'hffffe400)) |=> PSLVERR_OUT)
      else $error("unmapped access accepted");
endmodule : csad_asserts
bind csad_decoder csad_asserts u_asserts (.*);

/* csad_core_model.sv */
// Purpose: processor core issuing bus addresses
// Assumes: one address per request, a gap cycle between requests
// Notes:   lines inverted while idle so no stale address looks valid
`timescale 1ns/1ns
module csad_core_model (
   input  wire logic        clk_in,
   output logic      [31:0] addr_out,
   output logic             valid_out
);
   initial begin
      addr_out  = 32'h0;
      valid_out = 1'b0;
   end
   task automatic issue(input logic [31:0] a);
      @(posedge clk_in);
      addr_out  <= a;
      valid_out <= 1'b1;
      @(posedge clk_in);
      addr_out  <= ~a;
      valid_out <= 1'b0;
   endtask : issue
endmodule : csad_core_model

/* chip_select_address_decoder_tb.sv */
// Purpose: self-checking bench of the chip-select decoder
// Assumes: zero-wait apb slave, select one clock after the address
// Notes:   some masks exceed the 16 MB limit on purpose
`timescale 1ns/1ns
module chip_select_address_decoder_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, bus_addr, rd;
   logic        pready, pslverr, bus_valid, miss;
   logic [3:0]  sel_n;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;
   always #5 clk = ~clk;
   csad_core_model core (.clk_in(clk), .addr_out(bus_addr), .valid_out(bus_valid));
   csad_decoder DUT (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hf),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .BUS_ADDR_IN(bus_addr), .BUS_ADDR_VALID_IN(bus_valid),
      .SELECT_SPACE_ZERO_N_OUT(sel_n[0]), .SELECT_SPACE_ONE_N_OUT(sel_n[1]),
      .SELECT_SPACE_TWO_N_OUT(sel_n[2]), .SELECT_SPACE_THREE_N_OUT(sel_n[3]),
      .SPACE_MISS_OUT(miss));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic e);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      e  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic e;
      xfer(1'b1, a, d, e);
   endtask : wr
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input logic eexp);
      logic e;
      xfer(1'b0, a, 32'h0, e);
      chk(rd, exp);
      chk({31'h0, e}, {31'h0, eexp});
   endtask : rchk
   task automatic probe(input logic [31:0] a, input logic [3:0] s, input logic m);
      core.issue(a);
      #1;
      chk({27'h0, miss, sel_n}, {27'h0, m, s});
   endtask : probe
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rchk(32'hffffe400 + 32'(4 * i), (i < 2) ? 32'h3ff : 32'h1ff, 1'b0);
      end
      rchk(32'hffffe410, 32'h4, 1'b0);
      rchk(32'h00001000, 32'h0, 1'b1);
      probe(32'h00000000, 4'hb, 1'b0);
      probe(32'hffff7ffc, 4'hb, 1'b0);
      probe(32'hffff8000, 4'hf, 1'b1);
      rchk(32'hffffe414, 32'h00000130, 1'b0);
      wr(32'hffffe400, 32'hc0000003);
      wr(32'hffffe404, 32'hc0000000);
      wr(32'hffffe408, 32'h1fc8000f);
      wr(32'hffffe40c, 32'h000001ff);
      wr(32'hffffe410, 32'h0000000f);
      rchk(32'hffffe408, 32'h1fc8000f, 1'b0);
      probe(32'hc0000000, 4'he, 1'b0);
      probe(32'hc000fffc, 4'he, 1'b0);
      probe(32'hc0010000, 4'hf, 1'b1);
      probe(32'h1fcffffc, 4'hb, 1'b0);
      probe(32'h1fd00000, 4'hf, 1'b1);
      probe(32'h00fffffc, 4'h7, 1'b0);
      probe(32'h01000000, 4'hf, 1'b1);
      wr(32'hffffe410, 32'h0000000e);
      probe(32'hc0000000, 4'hd, 1'b0);
      probe(32'hc0004000, 4'hf, 1'b1);
      wr(32'hffffe400, 32'h0000ffff);
      wr(32'hffffe40c, 32'h0000ffff);
      wr(32'hffffe410, 32'h00000009);
      probe(32'h3fff0000, 4'he, 1'b0);
      probe(32'h40000000, 4'h7, 1'b0);
      probe(32'h80000000, 4'hf, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rchk(32'hffffe40c, 32'h1ff, 1'b0);
      probe(32'h80000000, 4'hb, 1'b0);
      stop_test();
   end
endmodule : chip_select_address_decoder_tb
